// *** verilog/chan_ctrl_pkg.sv ***
// Constants and carrier types for the channel control register bank
`default_nettype none
package chan_ctrl_pkg;
    // Register offsets
    localparam logic [7:0] PATT_PPM_CTRL_OFS = 8'h30;
    localparam logic [7:0] ADAPT_IRQ_EN_OFS = 8'h31;
    localparam logic [7:0] EYE_IRQ_LIMIT_OFS = 8'h32;
    localparam logic [7:0] EYE_ADAPT_LIMIT_OFS = 8'h33;
    // Reset values
    localparam logic [7:0] PATT_PPM_CTRL_RST = 8'h00;
    localparam logic [7:0] ADAPT_IRQ_EN_RST = 8'h00;
    localparam logic [7:0] EYE_IRQ_LIMIT_RST = 8'h11;
    localparam logic [7:0] EYE_ADAPT_LIMIT_RST = 8'h88;
    localparam logic [7:0] USER_PATTERN_RST = 8'h00;
    // Field positions, offset pattern_and_ppm_control
    localparam int OFFSET_COUNTER_HOLD_BIT = 7;
    localparam int SEARCH_OVERRIDE_ENABLE_BIT = 6;
    localparam int ALTERNATE_WORD_INVERT_BIT = 5;
    localparam int PATTERN_LOGIC_CLOCK_BIT = 3;
    localparam int USER_PATTERN_ENABLE_BIT = 2;
    localparam int POLY_SELECT_LSB = 0;
    // Field positions, offset adaptation_and_interrupt_enable
    localparam int PATTERN_ERROR_IRQ_BIT = 7;
    localparam int ADAPT_MODE_LSB = 5;
    localparam int MERIT_SELECT_LSB = 3;
    localparam int LOCK_LOSS_IRQ_BIT = 1;
    localparam int SIGNAL_LOSS_IRQ_BIT = 0;
    // Field positions, eye limits
    localparam int HORIZ_LIMIT_LSB = 4;
    localparam int VERT_LIMIT_LSB = 0;
    localparam int LIMIT_UNIT_SHIFT = 3;
    // Polynomial select codes for bits 1:0, named by register length
    localparam logic [1:0] POLY_7 = 2'b00;
    localparam logic [1:0] POLY_9 = 2'b01;
    localparam logic [1:0] POLY_15 = 2'b10;
    localparam logic [1:0] POLY_31 = 2'b11;
    localparam logic [30:0] LFSR_SEED = 31'h7fffffff;
    localparam int WORD_BITS = 16;

    typedef enum logic [2:0] {
        AD_IDLE = 3'b000,
        AD_LIN_FIRST = 3'b001,
        AD_FEEDBACK = 3'b010,
        AD_LIN_FINAL = 3'b011,
        AD_DONE = 3'b100
    } adapt_state_e;

    // Register access strobe from the management bus front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Channel status inputs
    typedef struct packed {
        logic lock;
        logic signal_detect;
        logic pattern_error;
        logic lin_optimal;
        logic feedback_optimal;
        logic [7:0] horiz_eye;
        logic [7:0] vert_eye;
    } chan_stat_s;
endpackage
`default_nettype wire

// *** verilog/chan_ctrl.sv ***
// Per-channel control register bank with pattern generator and adaptation sequencer
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Hold bit at pattern_and_ppm_control[7] freezes the offset counter for safe reading.
// - Search override enable routes search control from 0x13 bit 2.
// - With invert and user pattern, every second 16-bit word is complemented.
// - Pattern logic runs only while its clock enable is 1; toggle resets.
// - User pattern enable sends the fixed user pattern, not pseudo-random data.
// - Polynomial select 00/01/10/11 gives PRBS-7/9/15/31.
// - Pattern errors raise an interrupt when adaptation_and_interrupt_enable[7] is set and the pattern logic clock enable is 1.
// - Adapt mode 00 adapts nothing; 01 adapts linear equalizer only.
// - Mode 10: linear to optimal, then feedback, then linear again.
// - Mode 11: linear until 0x33 eye limits met, feedback, linear to optimal.
// - Merit select 01 horizontal, 10 vertical, 11 both; 00 invalid.
// - Lock loss raises an interrupt when adaptation_and_interrupt_enable[1] is set.
// - Signal detect loss raises an interrupt when adaptation_and_interrupt_enable[0] is set.
// - eye_opening_interrupt_threshold holds horizontal limit in bits 7:4, vertical in 3:0.
// - Each eye limit unit equals eight counts of opening.
// - Mode 11 minimum eye openings come from 0x33, each up to 15.
module chan_ctrl #(
    parameter int COUNT_W = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Register access
    input wire chan_ctrl_pkg::reg_req_s req_i,
    input wire logic [7:0] user_pattern_i,
    input wire logic [COUNT_W-1:0] offset_count_i,
    input wire logic search_reg_bit_i,
    input wire logic search_fsm_i,
    input wire logic [2:0] flag_clear_i,
    output logic [7:0] rdata_o,
    // Channel status
    input wire chan_ctrl_pkg::chan_stat_s stat_i,
    // Outputs to the datapath
    output logic [COUNT_W-1:0] offset_count_o,
    output logic search_o,
    output logic pattern_bit_o,
    output logic adapt_lin_o,
    output logic adapt_feedback_o,
    output logic [1:0] merit_select_o,
    output logic merit_valid_o,
    output logic eye_below_limit_o,
    output logic [2:0] flags_o,
    output logic irq_o
);
    logic [7:0] ctrl_q;
    logic [7:0] irq_en_q;
    logic [7:0] eye_irq_q;
    logic [7:0] eye_adapt_q;
    logic [30:0] lfsr_q;
    logic [30:0] lfsr_d;
    logic [3:0] bit_cnt_q;
    logic invert_q;
    logic [7:0] upat_q;
    logic [1:0] stat_s1_q;
    logic [1:0] stat_s2_q;
    logic [1:0] stat_prev_q;
    logic perr_s1_q;
    logic perr_s2_q;
    logic [2:0] flag_q;
    chan_ctrl_pkg::adapt_state_e state_q;
    logic [1:0] mode;
    logic clk_en;
    logic [10:0] h_limit;
    logic [10:0] v_limit;
    logic eye_met;

    function automatic logic [10:0] limit_counts(input logic [3:0] field);
        limit_counts = {7'h00, field} << chan_ctrl_pkg::LIMIT_UNIT_SHIFT;
    endfunction

    assign mode = irq_en_q[chan_ctrl_pkg::ADAPT_MODE_LSB +: 2];
    assign clk_en = ctrl_q[chan_ctrl_pkg::PATTERN_LOGIC_CLOCK_BIT];

    // ==========================================================
    // Register file
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ctrl_q <= chan_ctrl_pkg::PATT_PPM_CTRL_RST;
            irq_en_q <= chan_ctrl_pkg::ADAPT_IRQ_EN_RST;
            eye_irq_q <= chan_ctrl_pkg::EYE_IRQ_LIMIT_RST;
            eye_adapt_q <= chan_ctrl_pkg::EYE_ADAPT_LIMIT_RST;
        end else if (req_i.wr) begin
            case (req_i.addr)
                chan_ctrl_pkg::PATT_PPM_CTRL_OFS: begin
                    ctrl_q <= req_i.wdata;
                end
                chan_ctrl_pkg::ADAPT_IRQ_EN_OFS: begin
                    irq_en_q <= req_i.wdata & 8'hfb;
                end
                chan_ctrl_pkg::EYE_IRQ_LIMIT_OFS: begin
                    eye_irq_q <= req_i.wdata;
                end
                chan_ctrl_pkg::EYE_ADAPT_LIMIT_OFS: begin
                    eye_adapt_q <= req_i.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (req_i.rd) begin
            case (req_i.addr)
                chan_ctrl_pkg::PATT_PPM_CTRL_OFS: rdata_o <= ctrl_q;
                chan_ctrl_pkg::ADAPT_IRQ_EN_OFS: rdata_o <= irq_en_q;
                chan_ctrl_pkg::EYE_IRQ_LIMIT_OFS: rdata_o <= eye_irq_q;
                chan_ctrl_pkg::EYE_ADAPT_LIMIT_OFS: rdata_o <= eye_adapt_q;
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Offset counter hold and search override
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            offset_count_o <= '0;
        end else if (!ctrl_q[chan_ctrl_pkg::OFFSET_COUNTER_HOLD_BIT]) begin
            offset_count_o <= offset_count_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            search_o <= 1'b0;
        end else if (ctrl_q[chan_ctrl_pkg::SEARCH_OVERRIDE_ENABLE_BIT]) begin
            search_o <= search_reg_bit_i;
        end else begin
            search_o <= search_fsm_i;
        end
    end

    // ==========================================================
    // Pattern generator
    always_comb begin
        lfsr_d = {lfsr_q[29:0], 1'b0};
        case (ctrl_q[chan_ctrl_pkg::POLY_SELECT_LSB +: 2])
            chan_ctrl_pkg::POLY_7: lfsr_d[0] = lfsr_q[6] ^ lfsr_q[5];
            chan_ctrl_pkg::POLY_9: lfsr_d[0] = lfsr_q[8] ^ lfsr_q[4];
            chan_ctrl_pkg::POLY_15: lfsr_d[0] = lfsr_q[14] ^ lfsr_q[13];
            chan_ctrl_pkg::POLY_31: lfsr_d[0] = lfsr_q[30] ^ lfsr_q[27];
            default: lfsr_d[0] = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || !clk_en) begin
            lfsr_q <= chan_ctrl_pkg::LFSR_SEED;
            bit_cnt_q <= 4'h0;
            invert_q <= 1'b0;
            upat_q <= chan_ctrl_pkg::USER_PATTERN_RST;
            pattern_bit_o <= 1'b0;
        end else begin
            lfsr_q <= lfsr_d;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'hf) begin
                invert_q <= ~invert_q;
            end
            if (bit_cnt_q[2:0] == 3'h0) begin
                upat_q <= user_pattern_i;
            end else begin
                upat_q <= {upat_q[6:0], 1'b0};
            end
            if (ctrl_q[chan_ctrl_pkg::USER_PATTERN_ENABLE_BIT]) begin
                pattern_bit_o <= (bit_cnt_q[2:0] == 3'h0 ? user_pattern_i[7] : upat_q[6])
                    ^ (invert_q & ctrl_q[chan_ctrl_pkg::ALTERNATE_WORD_INVERT_BIT]);
            end else begin
                pattern_bit_o <= lfsr_q[0];
            end
        end
    end

    // ==========================================================
    // Adaptation sequencer
    assign h_limit = limit_counts(eye_adapt_q[7:4]);
    assign v_limit = limit_counts(eye_adapt_q[3:0]);
    assign eye_met = ({3'h0, stat_i.horiz_eye} >= h_limit) && ({3'h0, stat_i.vert_eye} >= v_limit);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || mode == 2'b00) begin
            state_q <= chan_ctrl_pkg::AD_IDLE;
        end else begin
            case (state_q)
                chan_ctrl_pkg::AD_IDLE: state_q <= chan_ctrl_pkg::AD_LIN_FIRST;
                chan_ctrl_pkg::AD_LIN_FIRST: begin
                    if (mode == 2'b01 && stat_i.lin_optimal) begin
                        state_q <= chan_ctrl_pkg::AD_DONE;
                    end else if (mode == 2'b10 && stat_i.lin_optimal) begin
                        state_q <= chan_ctrl_pkg::AD_FEEDBACK;
                    end else if (mode == 2'b11 && eye_met) begin
                        state_q <= chan_ctrl_pkg::AD_FEEDBACK;
                    end
                end
                chan_ctrl_pkg::AD_FEEDBACK: begin
                    if (stat_i.feedback_optimal) begin
                        state_q <= chan_ctrl_pkg::AD_LIN_FINAL;
                    end
                end
                chan_ctrl_pkg::AD_LIN_FINAL: begin
                    if (stat_i.lin_optimal) begin
                        state_q <= chan_ctrl_pkg::AD_DONE;
                    end
                end
                chan_ctrl_pkg::AD_DONE: state_q <= chan_ctrl_pkg::AD_DONE;
                default: state_q <= chan_ctrl_pkg::AD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            adapt_lin_o <= 1'b0;
            adapt_feedback_o <= 1'b0;
            merit_select_o <= 2'b00;
            merit_valid_o <= 1'b0;
        end else begin
            adapt_lin_o <= state_q == chan_ctrl_pkg::AD_LIN_FIRST || state_q == chan_ctrl_pkg::AD_LIN_FINAL;
            adapt_feedback_o <= state_q == chan_ctrl_pkg::AD_FEEDBACK;
            merit_select_o <= irq_en_q[chan_ctrl_pkg::MERIT_SELECT_LSB +: 2];
            merit_valid_o <= irq_en_q[chan_ctrl_pkg::MERIT_SELECT_LSB +: 2] != 2'b00;
        end
    end

    // ==========================================================
    // Event detection and interrupt
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            stat_s1_q <= 2'b00;
            stat_s2_q <= 2'b00;
            stat_prev_q <= 2'b00;
            perr_s1_q <= 1'b0;
            perr_s2_q <= 1'b0;
        end else begin
            stat_s1_q <= {stat_i.lock, stat_i.signal_detect};
            stat_s2_q <= stat_s1_q;
            stat_prev_q <= stat_s2_q;
            perr_s1_q <= stat_i.pattern_error;
            perr_s2_q <= perr_s1_q;
        end
    end

    // Flags: [2] pattern error, [1] lock loss, [0] signal loss; set wins
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            flag_q <= 3'b000;
        end else begin
            flag_q <= (flag_q & ~flag_clear_i) | {perr_s2_q & clk_en,
                stat_prev_q[1] & ~stat_s2_q[1], stat_prev_q[0] & ~stat_s2_q[0]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            flags_o <= 3'b000;
            irq_o <= 1'b0;
            eye_below_limit_o <= 1'b0;
        end else begin
            flags_o <= flag_q;
            irq_o <= (flag_q[2] & irq_en_q[chan_ctrl_pkg::PATTERN_ERROR_IRQ_BIT])
                | (flag_q[1] & irq_en_q[chan_ctrl_pkg::LOCK_LOSS_IRQ_BIT])
                | (flag_q[0] & irq_en_q[chan_ctrl_pkg::SIGNAL_LOSS_IRQ_BIT]);
            eye_below_limit_o <= ({3'h0, stat_i.horiz_eye} < limit_counts(eye_irq_q[7:4]))
                | ({3'h0, stat_i.vert_eye} < limit_counts(eye_irq_q[3:0]));
        end
    end

    // ==========================================================
    // Checks
    hold_count_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        ctrl_q[7] && $past(ctrl_q[7]) |-> $stable(offset_count_o))
        else $error("offset count moved while held");
    lock_irq_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        flag_q[1] && irq_en_q[1] |=> irq_o)
        else $error("lock loss interrupt missing");
    flag_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        flag_q[0] && !flag_clear_i[0] |=> flag_q[0])
        else $error("signal loss flag dropped");
    mode_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        mode == 2'b00 |=> ##1 !adapt_lin_o && !adapt_feedback_o)
        else $error("adaptation active in mode zero");
    gen_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !clk_en |=> bit_cnt_q == 4'h0 && !pattern_bit_o)
        else $error("pattern logic ran while disabled");
    search_sel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        ctrl_q[6] |=> search_o == $past(search_reg_bit_i))
        else $error("search override not applied");
    merit_bad_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        irq_en_q[4:3] == 2'b00 |=> !merit_valid_o)
        else $error("merit value zero accepted");
    no_irq_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        irq_en_q[7] == 1'b0 && irq_en_q[1:0] == 2'b00 |=> !irq_o)
        else $error("interrupt with all enables off");
endmodule
`default_nettype wire

// *** test/mgmt_host.sv ***
// Management bus host model issuing register accesses
`timescale 1ns/100ps
`default_nettype none
module mgmt_host (
    // Clock
    input wire logic clk_sys_i,
    // Register access
    input wire logic [7:0] rdata_i,
    output var chan_ctrl_pkg::reg_req_s req_o
);
    initial req_o = '0;

    // ==========================================
    // Bus cycles
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req_o <= '0;
    endtask

    // Read data lands one cycle after the read edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i);
        req_o <= '0;
        #1;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// *** test/chan_ctrl_tb.sv ***
// Self-checking testbench for the channel control register bank
`timescale 1ns/100ps
`default_nettype none
module chan_ctrl_tb;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    chan_ctrl_pkg::reg_req_s req;
    chan_ctrl_pkg::chan_stat_s stat;
    logic [7:0] user_pattern, rdata, rv;
    logic [15:0] cnt_in, cnt_out;
    logic search_reg, search_fsm, search, pbit, a_lin, a_fb, m_valid, below, irq;
    logic [2:0] clr, flags;
    logic [1:0] merit;
    int n_mismatch = 0;
    int check_count = 0;
    int ones;

    always #5 clk_sys_i = ~clk_sys_i;

    mgmt_host host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .req_o(req));

    chan_ctrl uut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .req_i(req), .user_pattern_i(user_pattern),
        .offset_count_i(cnt_in), .search_reg_bit_i(search_reg), .search_fsm_i(search_fsm),
        .flag_clear_i(clr), .rdata_o(rdata), .stat_i(stat), .offset_count_o(cnt_out),
        .search_o(search), .pattern_bit_o(pbit), .adapt_lin_o(a_lin), .adapt_feedback_o(a_fb),
        .merit_select_o(merit), .merit_valid_o(m_valid), .eye_below_limit_o(below),
        .flags_o(flags), .irq_o(irq)
    );

    // ==========================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd_reg(a, rv);
        chk({8'h00, rv}, {8'h00, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic count_ones(input int len, output int n);
        n = 0;
        repeat (len) begin
            @(posedge clk_sys_i);
            #1;
            n += (pbit === 1'b1) ? 1 : 0;
        end
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys_i);
        n_mismatch++;
        give_verdict();
    end

    // ==========================================
    // Tests
    initial begin
        stat = '0;
        stat.lock = 1'b1;
        stat.signal_detect = 1'b1;
        user_pattern = 8'hff;
        cnt_in = 16'h1234;
        search_reg = 1'b1;
        search_fsm = 1'b0;
        clr = 3'b000;
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rchk(8'h30, 8'h00);
        rchk(8'h31, 8'h00);
        rchk(8'h32, 8'h11);
        rchk(8'h33, 8'h88);
        host.wr_reg(8'h40, 8'hff);
        rchk(8'h40, 8'h00);
        host.wr_reg(8'h31, 8'hff);
        rchk(8'h31, 8'hfb);
        host.wr_reg(8'h32, 8'h23);
        rchk(8'h32, 8'h23);
        for (int v = 0; v < 4; v++) begin
            host.wr_reg(8'h31, {3'b000, v[1:0], 3'b000});
            cyc(2);
            chk({14'h0, merit}, 16'(v));
            chk({15'h0, m_valid}, 16'(v != 0));
        end
        @(posedge clk_sys_i);
        stat.horiz_eye <= 8'd16;
        stat.vert_eye <= 8'd24;
        cyc(3);
        chk({15'h0, below}, 16'h0000);
        @(posedge clk_sys_i);
        stat.horiz_eye <= 8'd15;
        cyc(3);
        chk({15'h0, below}, 16'h0001);
        @(posedge clk_sys_i);
        stat.horiz_eye <= 8'd16;
        stat.vert_eye <= 8'd23;
        cyc(3);
        chk({15'h0, below}, 16'h0001);
        chk(cnt_out, 16'h1234);
        host.wr_reg(8'h30, 8'h80);
        @(posedge clk_sys_i);
        cnt_in <= 16'h5678;
        cyc(3);
        chk(cnt_out, 16'h1234);
        host.wr_reg(8'h30, 8'h40);
        cyc(2);
        chk(cnt_out, 16'h5678);
        chk({15'h0, search}, 16'h0001);
        @(posedge clk_sys_i);
        search_reg <= 1'b0;
        search_fsm <= 1'b1;
        cyc(2);
        chk({15'h0, search}, 16'h0000);
        host.wr_reg(8'h30, 8'h00);
        cyc(2);
        chk({15'h0, search}, 16'h0001);
        host.wr_reg(8'h30, 8'h2c);
        cyc(4);
        count_ones(64, ones);
        chk(16'(ones), 16'd32);
        host.wr_reg(8'h30, 8'h0c);
        cyc(4);
        count_ones(64, ones);
        chk(16'(ones), 16'd64);
        // One full period of PRBS-7, PRBS-9 and PRBS-15 holds one more one than zeros
        host.wr_reg(8'h30, 8'h08);
        cyc(4);
        count_ones(127, ones);
        chk(16'(ones), 16'd64);
        host.wr_reg(8'h30, 8'h09);
        cyc(4);
        count_ones(511, ones);
        chk(16'(ones), 16'd256);
        host.wr_reg(8'h30, 8'h0a);
        cyc(4);
        count_ones(32767, ones);
        chk(16'(ones), 16'd16384);
        // Lock loss enabled, signal loss detected but masked
        host.wr_reg(8'h30, 8'h00);
        host.wr_reg(8'h31, 8'h02);
        @(posedge clk_sys_i);
        stat.lock <= 1'b0;
        stat.signal_detect <= 1'b0;
        cyc(8);
        chk({13'h0, flags}, 16'h0003);
        chk({15'h0, irq}, 16'h0001);
        @(posedge clk_sys_i);
        clr <= 3'b010;
        @(posedge clk_sys_i);
        clr <= 3'b000;
        cyc(2);
        chk({13'h0, flags}, 16'h0001);
        chk({15'h0, irq}, 16'h0000);
        host.wr_reg(8'h31, 8'h81);
        cyc(2);
        chk({15'h0, irq}, 16'h0001);
        @(posedge clk_sys_i);
        clr <= 3'b001;
        stat.pattern_error <= 1'b1;
        @(posedge clk_sys_i);
        clr <= 3'b000;
        cyc(8);
        chk({13'h0, flags}, 16'h0000);
        host.wr_reg(8'h30, 8'h08);
        cyc(8);
        chk({13'h0, flags}, 16'h0004);
        chk({15'h0, irq}, 16'h0001);
        @(posedge clk_sys_i);
        stat.pattern_error <= 1'b0;
        cyc(4);
        chk({13'h0, flags}, 16'h0004);
        @(posedge clk_sys_i);
        clr <= 3'b100;
        @(posedge clk_sys_i);
        clr <= 3'b000;
        cyc(2);
        chk({15'h0, irq}, 16'h0000);
        host.wr_reg(8'h31, 8'h00);
        cyc(3);
        chk({14'h0, a_lin, a_fb}, 16'h0000);
        host.wr_reg(8'h31, 8'h40);
        cyc(4);
        chk({14'h0, a_lin, a_fb}, 16'h0002);
        @(posedge clk_sys_i);
        stat.lin_optimal <= 1'b1;
        cyc(4);
        chk({14'h0, a_lin, a_fb}, 16'h0001);
        @(posedge clk_sys_i);
        stat.lin_optimal <= 1'b0;
        stat.feedback_optimal <= 1'b1;
        cyc(4);
        chk({14'h0, a_lin, a_fb}, 16'h0002);
        @(posedge clk_sys_i);
        stat.lin_optimal <= 1'b1;
        stat.feedback_optimal <= 1'b0;
        cyc(4);
        chk({14'h0, a_lin, a_fb}, 16'h0000);
        // Mode 11: eye limits, not linear optimum, end the first phase
        host.wr_reg(8'h31, 8'h00);
        host.wr_reg(8'h33, 8'h42);
        rchk(8'h33, 8'h42);
        host.wr_reg(8'h31, 8'h60);
        cyc(4);
        chk({14'h0, a_lin, a_fb}, 16'h0002);
        @(posedge clk_sys_i);
        stat.horiz_eye <= 8'd32;
        stat.vert_eye <= 8'd16;
        cyc(4);
        chk({14'h0, a_lin, a_fb}, 16'h0001);
        // Mode 01: linear only, done at its optimum
        host.wr_reg(8'h31, 8'h00);
        @(posedge clk_sys_i);
        stat.lin_optimal <= 1'b0;
        host.wr_reg(8'h31, 8'h20);
        cyc(4);
        chk({14'h0, a_lin, a_fb}, 16'h0002);
        @(posedge clk_sys_i);
        stat.lin_optimal <= 1'b1;
        cyc(4);
        chk({14'h0, a_lin, a_fb}, 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
